// file: adcu_defs.vh
// constants shared by the converter control unit
`ifndef ADCU_DEFS_VH
`define ADCU_DEFS_VH

// register indices; byte address is four times the index
`define ADCU_IDX_CTRL 8'h1d
`define ADCU_IDX_RESULT 8'h1e
`define ADCU_IDX_CFG 8'h20
`define ADCU_IDX_IRQ_STAT 8'h21
`define ADCU_IDX_IRQ_MASK 8'h22
`define ADCU_ADDR_W 8

// control register fields
`define ADCU_CH_HI 2
`define ADCU_CH_LO 0
`define ADCU_CK_HI 4
`define ADCU_CK_LO 3
`define ADCU_START_BIT 5
`define ADCU_POWER_BIT 6
`define ADCU_DONE_BIT 7

// config register: reference source, bit 6 as in the endpoint register
`define ADCU_REF_BIT 6
`define ADCU_REF_RESET 1'b1

// interrupt bit: conversion finished
`define ADCU_IRQ_DONE 0

// channel codes for the two reference pins
`define ADCU_CH_VLOW 3'h6
`define ADCU_CH_VHIGH 3'h7
`define ADCU_REF_LOW_PIN 6
`define ADCU_REF_HIGH_PIN 7

// reset values
`define ADCU_CTRL_RESET 7'h00
`define ADCU_BYTE_ZERO 8'h00

// conversion clock half periods in 100 MHz system cycles for 6, 3, 1.5
// and 0.75 MHz, rounded down so the rate is never below nominal
`define ADCU_HALF_0 8'h08
`define ADCU_HALF_1 8'h10
`define ADCU_HALF_2 8'h21
`define ADCU_HALF_3 8'h42
`define ADCU_DIV_W 8

`endif

// file: adcu_adc_control_unit.v
// control logic of the six-channel 8-bit converter with its bus slave
//
// What this block does
// - channel field picks inputs 0-5, low reference (110) or high (111)
// - clock field selects 6, 3, 1.5 or 0.75 MHz conversion clock
// - start bit rising resets converter and result; falling starts it
// - power bit one runs the converter, zero turns it off
// - bit seven reads zero once conversion has ended, result ready
// - separate 8-bit result register holds the conversion outcome
// - inputs share port B bits 0-5, references share bits 6 and 7
// - low and high references bound the full-scale input range
// - pins not used for conversion stay ordinary I/O lines
// - a one-time option enables or disables the whole converter
// - reference bit six chooses supply rails (1, default) or pins (0)
`timescale 1ns/10ps
`include "adcu_defs.vh"

module adcu_adc_control_unit (
    // clock and reset
    input wire sys_clk,
    input wire nrst,
    // avalon-mm slave
    input wire [`ADCU_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // interrupt
    output wire irq,
    // one-time converter option, sampled after reset
    input wire option_adc_enable,
    // analog converter core
    output reg [2:0] channel_select,
    output reg conv_clock,
    output reg converter_power_on,
    output reg reference_source_select,
    output reg core_reset,
    output reg core_start,
    input wire core_done,
    input wire [7:0] core_data,
    // port b pin sharing
    input wire [7:0] gpio_out,
    input wire [7:0] gpio_oe,
    input wire [7:0] pin_in,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe,
    output wire [7:0] gpio_in,
    output reg [7:0] analog_pin_en
);

////////////////////////////////////////////////////////////////////////////
// reset release and option strap

reg rst_meta;
reg rst_sync;
wire rst_n = rst_sync;

// asynchronous assert, synchronous release through two flops
always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        rst_meta <= 1'b0;
        rst_sync <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_sync <= rst_meta;
    end
end

reg strap_taken;
reg adc_option;

// sample the option once, at the first edge after release
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        strap_taken <= 1'b0;
        adc_option <= 1'b0;
    end else if (!strap_taken) begin
        strap_taken <= 1'b1;
        adc_option <= option_adc_enable;
    end
end

////////////////////////////////////////////////////////////////////////////
// bus slave: one wait cycle, then the access completes

reg ack;
wire req = avs_read | avs_write;
wire take = req & ack;
wire [`ADCU_ADDR_W-1:0] idx = {2'b00, avs_address[`ADCU_ADDR_W-1:2]};

assign avs_waitrequest = req & ~ack;

reg [6:0] ctrl;
reg done_n;
reg [7:0] result;
reg [7:0] irq_stat;
reg [7:0] irq_mask;

// ack rises one cycle after a request and drops after it is taken
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        ack <= 1'b0;
    end else begin
        ack <= req & ~ack;
    end
end

// read data is registered in the wait cycle, unmapped reads give zero
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
        case (idx)
            `ADCU_IDX_CTRL:
                avs_readdata <= {24'h00_0000, done_n, ctrl};
            `ADCU_IDX_RESULT:
                avs_readdata <= {24'h00_0000, result};
            `ADCU_IDX_CFG:
                avs_readdata <= {24'h00_0000, 1'b0,
                    reference_source_select, 6'h00};
            `ADCU_IDX_IRQ_STAT:
                avs_readdata <= {24'h00_0000, irq_stat};
            `ADCU_IDX_IRQ_MASK:
                avs_readdata <= {24'h00_0000, irq_mask};
            default:
                avs_readdata <= 32'h0000_0000;
        endcase
    end
end

wire wr_ctrl = take & avs_write & (idx == `ADCU_IDX_CTRL);
wire wr_cfg = take & avs_write & (idx == `ADCU_IDX_CFG);
wire wr_mask = take & avs_write & (idx == `ADCU_IDX_IRQ_MASK);
wire rd_stat = take & avs_read & (idx == `ADCU_IDX_IRQ_STAT);

// control bits 6..0 are written by software; bit 7 is status only
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        ctrl <= `ADCU_CTRL_RESET;
    end else if (wr_ctrl) begin
        ctrl <= avs_writedata[6:0];
    end
end

// reference source and interrupt mask
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        reference_source_select <= `ADCU_REF_RESET;
        irq_mask <= `ADCU_BYTE_ZERO;
    end else begin
        if (wr_cfg) begin
            reference_source_select <= avs_writedata[`ADCU_REF_BIT];
        end
        if (wr_mask) begin
            irq_mask <= avs_writedata[7:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// conversion sequencing

localparam ST_IDLE = 3'b001;
localparam ST_HOLD = 3'b010;
localparam ST_BUSY = 3'b100;

reg [2:0] state;
reg [2:0] next_state;
reg start_prev;
// taken from the register, not the registered pin, so a write that sets
// power and start together is not missed by the start edge detector
wire enabled = adc_option & ctrl[`ADCU_POWER_BIT];
wire start_bit = ctrl[`ADCU_START_BIT];
wire start_rise = start_bit & ~start_prev;
wire start_fall = ~start_bit & start_prev;
wire finish = (state == ST_BUSY) & core_done & enabled;

// next state: rise holds the core in reset, fall launches conversion
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: if (start_rise && enabled) next_state = ST_HOLD;
        ST_HOLD: begin
            if (!enabled) next_state = ST_IDLE;
            else if (start_fall) next_state = ST_BUSY;
        end
        ST_BUSY: begin
            if (!enabled || core_done) next_state = ST_IDLE;
            else if (start_rise) next_state = ST_HOLD;
        end
        default: next_state = ST_IDLE;
    endcase
end

// state, core strobes, done flag and result
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        start_prev <= 1'b0;
        core_reset <= 1'b1;
        core_start <= 1'b0;
        done_n <= 1'b1;
        result <= `ADCU_BYTE_ZERO;
    end else begin
        state <= next_state;
        start_prev <= start_bit;
        // core held in reset while the start bit is high or power is off
        core_reset <= ~enabled | start_bit;
        core_start <= (state == ST_HOLD) & start_fall & enabled;
        if (start_rise && enabled) begin
            result <= `ADCU_BYTE_ZERO;
            done_n <= 1'b1;
        end else if (finish) begin
            result <= core_data;
            done_n <= 1'b0;
        end else if (state == ST_HOLD && start_fall) begin
            done_n <= 1'b1;
        end
    end
end

// outputs toward the core follow the control register
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        channel_select <= 3'h0;
        converter_power_on <= 1'b0;
    end else begin
        channel_select <= ctrl[`ADCU_CH_HI:`ADCU_CH_LO];
        converter_power_on <= ctrl[`ADCU_POWER_BIT] & adc_option;
    end
end

////////////////////////////////////////////////////////////////////////////
// conversion clock divider

reg [`ADCU_DIV_W-1:0] div_cnt;
reg [`ADCU_DIV_W-1:0] half_len;

// half period chosen by the clock field
always @* begin
    case (ctrl[`ADCU_CK_HI:`ADCU_CK_LO])
        2'b00: half_len = `ADCU_HALF_0;
        2'b01: half_len = `ADCU_HALF_1;
        2'b10: half_len = `ADCU_HALF_2;
        default: half_len = `ADCU_HALF_3;
    endcase
end

// the clock stands low while the converter is off to save power
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        div_cnt <= 8'h00;
        conv_clock <= 1'b0;
    end else if (!enabled) begin
        div_cnt <= 8'h00;
        conv_clock <= 1'b0;
    end else if (div_cnt >= half_len - 8'h01) begin
        div_cnt <= 8'h00;
        conv_clock <= ~conv_clock;
    end else begin
        div_cnt <= div_cnt + 8'h01;
    end
end

////////////////////////////////////////////////////////////////////////////
// pin sharing with port b

// only the selected input and, with external references, both
// reference pins are taken from the port; the rest stay digital
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        analog_pin_en <= `ADCU_BYTE_ZERO;
    end else begin
        analog_pin_en <= `ADCU_BYTE_ZERO;
        if (enabled) begin
            analog_pin_en[ctrl[`ADCU_CH_HI:`ADCU_CH_LO]] <= 1'b1;
            if (!reference_source_select) begin
                analog_pin_en[`ADCU_REF_LOW_PIN] <= 1'b1;
                analog_pin_en[`ADCU_REF_HIGH_PIN] <= 1'b1;
            end
        end
    end
end

// digital drivers are released on analog pins only
assign pin_out = gpio_out;
assign pin_oe = gpio_oe & ~analog_pin_en;
assign gpio_in = pin_in & ~analog_pin_en;

////////////////////////////////////////////////////////////////////////////
// interrupt status: sticky, cleared by reading, set wins over the clear

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        irq_stat <= `ADCU_BYTE_ZERO;
    end else begin
        // clear only what the read returned: an event landing in the
        // wait cycle after the data was latched must not be lost
        if (rd_stat) begin
            irq_stat <= irq_stat & ~avs_readdata[7:0];
        end
        if (finish) begin
            irq_stat[`ADCU_IRQ_DONE] <= 1'b1;
        end
    end
end

assign irq = |(irq_stat & irq_mask);

endmodule // adcu_adc_control_unit

// file: adcu_chk.sv
// assertion checker for the converter control unit ports
`timescale 1ns/10ps
module adcu_chk (
    // clock and reset
    input wire sys_clk,
    input wire nrst,
    // register bus
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire irq,
    // core and pins
    input wire [2:0] channel_select,
    input wire conv_clock,
    input wire converter_power_on,
    input wire core_reset,
    input wire core_start,
    input wire core_done,
    input wire [7:0] pin_in,
    input wire [7:0] gpio_in,
    input wire [7:0] analog_pin_en
);
    wire take = !avs_waitrequest && (avs_read || avs_write);
    wire wr_ctrl = take && avs_write && avs_address == 8'h74;
    wire rd_stat = take && avs_read && avs_address == 8'h84;
    wire rise;
    reg [7:0] wd_q;
    reg [7:0] gap;
    reg ck_q;
    reg seen;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    assign rise = conv_clock && !ck_q;
    ////////////////////////////////////////////////////////////////
    // period is measured only in quiet powered spans: start may resync
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wd_q <= 8'h00;
            gap <= 8'h00;
            ck_q <= 1'b0;
            seen <= 1'b0;
        end else begin
            if (wr_ctrl)
                wd_q <= avs_writedata[7:0];
            ck_q <= conv_clock;
            gap <= rise ? 8'h01 : (gap == 8'hff ? gap : gap + 8'h01);
            seen <= converter_power_on && !core_reset && !core_start &&
                (seen || rise);
        end
    end
    ////////////////////////////////////////////////////////////////
    AST_CH_COPY: assert property (wr_ctrl |-> ##[1:2]
        channel_select == wd_q[2:0]) else $error("channel not copied");
    AST_POWER_OFF: assert property (wr_ctrl && !avs_writedata[6]
        |-> ##[1:2] !converter_power_on) else $error("power stays on");
    AST_CLK_IDLE: assert property (!converter_power_on [*3]
        |-> !conv_clock) else $error("clock runs while off");
    AST_CLK_PERIOD: assert property (rise && seen |-> gap == 8'h10 ||
        gap == 8'h20 || gap == 8'h42 || gap == 8'h84)
        else $error("bad conversion clock period");
    AST_START_PULSE: assert property (core_start |=> !core_start)
        else $error("start pulse too long");
    AST_START_CAUSE: assert property (core_start |-> !core_reset &&
        $past(wr_ctrl, 2) && !$past(avs_writedata[5], 2))
        else $error("start without falling start bit");
    AST_IRQ_CLEAR: assert property (rd_stat && avs_readdata[0] &&
        !core_done |=> !irq) else $error("irq not cleared by read");
    AST_PIN_SHARE: assert property (gpio_in == (pin_in & ~analog_pin_en))
        else $error("gpio input not masked");
    AST_READ_WIDTH: assert property (avs_read && take |->
        avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule // adcu_chk

bind adcu_adc_control_unit adcu_chk u_adcu_chk (.sys_clk(sys_clk),
    .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .channel_select(channel_select), .conv_clock(conv_clock),
    .converter_power_on(converter_power_on), .core_reset(core_reset),
    .core_start(core_start), .core_done(core_done), .pin_in(pin_in),
    .gpio_in(gpio_in), .analog_pin_en(analog_pin_en));

// file: adcu_core_model.sv
// behavioural analog converter core facing the control unit
`timescale 1ns/10ps
module adcu_core_model (
    // clock
    input wire sys_clk,
    // control from the block
    input wire core_reset,
    input wire core_start,
    // result and latency chosen by the bench
    input wire [7:0] sample,
    input wire [5:0] delay,
    // answer
    output reg core_done = 1'b0,
    output reg [7:0] core_data = 8'h00
);
    reg [5:0] cnt = 6'h00;
    reg busy = 1'b0;
    // data toggles when not answering so a stale value never matches
    always @(posedge sys_clk) begin
        core_done <= 1'b0;
        core_data <= ~core_data;
        if (core_reset) begin
            busy <= 1'b0;
        end else if (core_start) begin
            busy <= 1'b1;
            cnt <= delay;
        end else if (busy && cnt == 6'h00) begin
            busy <= 1'b0;
            core_done <= 1'b1;
            core_data <= sample;
        end else if (busy) begin
            cnt <= cnt - 6'h01;
        end
    end
endmodule // adcu_core_model

// file: test_adc_control_unit.sv
// self-checking bench for the converter control unit
`timescale 1ns/10ps
module test_adc_control_unit;
    reg sys_clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg option_adc_enable = 1'b1;
    reg [7:0] gpio_out = 8'h00;
    reg [7:0] gpio_oe = 8'h00;
    reg [7:0] pin_in = 8'h00;
    reg [7:0] sample = 8'h00;
    reg [5:0] delay = 6'h00;
    reg [7:0] cw;
    reg [7:0] pe;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, irq, conv_clock, converter_power_on;
    wire reference_source_select, core_reset, core_start, core_done;
    wire [2:0] channel_select;
    wire [7:0] core_data, pin_out, pin_oe, gpio_in, analog_pin_en;
    int fails = 0;
    int n_tests = 0;
    int starts = 0;
    int i;
    logic [31:0] exp_q[$];
    always #5 sys_clk = ~sys_clk;
    adcu_adc_control_unit u_adcu_adc_control_unit (.sys_clk(sys_clk),
        .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .option_adc_enable(option_adc_enable),
        .channel_select(channel_select), .conv_clock(conv_clock),
        .converter_power_on(converter_power_on), .core_reset(core_reset),
        .reference_source_select(reference_source_select),
        .core_start(core_start), .core_done(core_done),
        .core_data(core_data), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .gpio_in(gpio_in), .analog_pin_en(analog_pin_en));
    adcu_core_model u_adcu_core_model (.sys_clk(sys_clk),
        .core_reset(core_reset), .core_start(core_start), .sample(sample),
        .delay(delay), .core_done(core_done), .core_data(core_data));
    ////////////////////////////////////////////////////////////////
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one bus cycle held until waitrequest is sampled low
    task bus(input bit rd, input [7:0] a, input [7:0] d, input [7:0] e);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        if (rd)
            exp_q.push_back({24'h0, e});
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
            fails++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // bounded wait for the core answer, then one edge to settle
    task wait_done;
        int n;
        n = 0;
        while (core_done !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check("done_wait", n < 200, 1);
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // read answers are compared in the order the requests were made
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            check("readdata", avs_readdata, exp_q.pop_front());
        if (core_start === 1'b1)
            starts++;
    end
    initial begin
        #100000;
        fails++;
        stop_test;
    end
    initial begin
        void'($urandom(97832));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(1, 8'h74, 8'h00, 8'h80);
        bus(1, 8'h80, 8'h00, 8'h40);
        bus(1, 8'h90, 8'h00, 8'h00);
        bus(0, 8'h88, 8'h01, 8'h00);
        // every channel and clock code; mask off once, pins as reference
        for (i = 0; i < 8; i++) begin
            cw = 8'h40 | ((i % 4) << 3) | i;
            sample <= $urandom;
            delay <= $urandom % 30;
            gpio_out <= $urandom;
            gpio_oe <= $urandom;
            pin_in <= $urandom;
            if (i == 5)
                bus(0, 8'h88, 8'h00, 8'h00);
            if (i == 6)
                bus(0, 8'h80, 8'h00, 8'h00);
            bus(0, 8'h74, cw | 8'h20, 8'h00);
            bus(1, 8'h78, 8'h00, 8'h00);
            bus(0, 8'h74, cw, 8'h00);
            wait_done;
            check("irq", irq, i != 5);
            bus(1, 8'h74, 8'h00, cw);
            bus(1, 8'h78, 8'h00, sample);
            bus(1, 8'h84, 8'h00, 8'h01);
            // expected analog pins: the channel, plus both references from channel 6 on (pins as reference)
            pe = (8'h01 << i) | (i > 5 ? 8'hc0 : 8'h00);
            check("pin_en", analog_pin_en, pe);
            check("ref_sel", reference_source_select, i < 6);
            check("pins", {pin_out, pin_oe},
                {gpio_out, gpio_oe & ~pe});
            check("gpio_in", gpio_in, pin_in & ~pe);
            if (i == 5)
                bus(0, 8'h88, 8'h01, 8'h00);
            repeat (300) @(posedge sys_clk);
            bus(0, 8'h74, 8'h00, 8'h00);
        end
        // start without power, write to the read-only result
        bus(0, 8'h74, 8'h20, 8'h00);
        bus(0, 8'h74, 8'h00, 8'h00);
        bus(0, 8'h78, 8'hff, 8'h00);
        bus(1, 8'h78, 8'h00, sample);
        repeat (20) @(posedge sys_clk);
        check("starts", starts, 8);
        // second reset with the converter option off
        option_adc_enable <= 1'b0;
        nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(0, 8'h74, 8'h60, 8'h00);
        bus(0, 8'h74, 8'h40, 8'h00);
        repeat (20) @(posedge sys_clk);
        check("power", converter_power_on, 0);
        check("starts", starts, 8);
        check("queue", exp_q.size(), 0);
        stop_test;
    end
endmodule // test_adc_control_unit
